// *** uic_cfg.svh ***
// Register offsets, field positions, reset values and timing counts of the serial port control block
`ifndef UIC_CFG_SVH
`define UIC_CFG_SVH
`define UIC_OFS_CLK 8'h00
`define UIC_OFS_MOD 8'h04
`define UIC_OFS_BR 8'h08
`define UIC_OFS_CTL 8'h0c
`define UIC_OFS_TXD 8'h10
`define UIC_OFS_RXD 8'h14
`define UIC_OFS_INTF 8'h18
`define UIC_OFS_INTE 8'h1c
`define UIC_OFS_TDMA 8'h20
`define UIC_OFS_RDMA 8'h24
`define UIC_OFS_CAWF 8'h28
`define UIC_MSK_CLK 16'h0133
`define UIC_MSK_MOD 16'h1f7f
`define UIC_MSK_BR 12'hfff
`define UIC_CLK_DEBUG_RUN 8
`define UIC_CLK_DIV_LSB 4
`define UIC_CLK_SRC_LSB 0
`define UIC_BR_RELOAD_LSB 0
`define UIC_CTL_SOFT_RESET 1
`define UIC_CTL_MODULE_ENABLE 0
`define UIC_FLAGS_RST 7'h01
`define UIC_SRST_CYCLES 3'h4
`define UIC_IR_PULSE 4'h3
`define UIC_OVS_FAST 4'h3
`define UIC_OVS_SLOW 4'hf
`define UIC_HALF_FAST 4'h1
`define UIC_HALF_SLOW 4'h7
`endif

// *** uic_pkg.sv ***
// Types shared by the serial port control block
package uic_pkg;
  typedef struct packed {
    logic tend;
    logic fe;
    logic pe;
    logic oe;
    logic rb2;
    logic rb1;
    logic tbe;
  } uic_flags_t;
  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic carrier_phase_select;
    logic carrier_enable;
    logic baud_prescale_select;
    logic rx_line_invert;
    logic tx_line_invert;
    logic rsvd7;
    logic input_pullup_enable;
    logic output_drive_mode;
    logic infrared_mode_enable;
    logic char_length_select;
    logic parity_enable;
    logic parity_odd_select;
    logic stop_length_select;
  } uic_mode_t;
  typedef enum logic [2:0] {
    UIC_IDLE = 3'b000,
    UIC_START = 3'b001,
    UIC_DATA = 3'b010,
    UIC_PAR = 3'b011,
    UIC_STOP = 3'b100
  } uic_line_st_t;
endpackage

// *** uic_clk_gen.sv ***
// Operating clock source select, divider, gating and sampling tick generator
`timescale 1ns/100ps
module uic_clk_gen (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [3:0] src_tick,
  input wire logic [1:0] clk_src,
  input wire logic [1:0] clk_div,
  input wire logic run,
  input wire logic [7:0] reload,
  output logic op_tick,
  output logic sample_tick
);
  logic [2:0] div_q;
  logic [7:0] rl_q;
  logic [3:0] m4;
  logic [2:0] mask;
  logic sel;

  // Divider only applies to the two oscillator sources
  always_comb begin
    sel = src_tick[clk_src];
    m4 = (4'h1 << clk_div) - 4'h1;
    mask = (clk_src == 2'h0 || clk_src == 2'h2) ? m4[2:0] : 3'h0;
    op_tick = run & sel & ((div_q & mask) == mask);
    sample_tick = op_tick && (rl_q == reload);
  end

  // Source tick divider
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      div_q <= 3'h0;
    end else if (run & sel) begin
      div_q <= div_q + 3'h1;
    end
  end

  // Reload counter of the sampling clock
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rl_q <= 8'h00;
    end else if (op_tick) begin
      rl_q <= sample_tick ? 8'h00 : rl_q + 8'h01;
    end
  end
endmodule

// *** uic_rx_fifo.sv ***
// Two-entry receive buffer, oldest entry first
`timescale 1ns/100ps
module uic_rx_fifo #(parameter int W = 10) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clear,
  input wire logic push,
  input wire logic pop,
  input wire logic [W-1:0] wdata,
  output logic [1:0] count,
  output logic [W-1:0] head,
  output logic [W-1:0] next
);
  logic [W-1:0] mem_q [2];
  logic [1:0] count_q;

  // Head is zero while empty
  assign count = count_q;
  assign head = (count_q != 2'h0) ? mem_q[0] : '0;
  assign next = mem_q[1];

  // Storage shifts forward on a pop
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      if (push && (count_q == 2'h0 || (pop && count_q == 2'h1))) begin
        mem_q[0] <= wdata;
      end else if (pop) begin
        mem_q[0] <= mem_q[1];
      end
      if (push && count_q == 2'h1 && !pop) begin
        mem_q[1] <= wdata;
      end
    end
  end

  // Fill level
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      count_q <= 2'h0;
    end else if (clear) begin
      count_q <= 2'h0;
    end else begin
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// *** uic_uart_ctrl.sv ***
// Serial port with interrupt flags, DMA requests and configuration registers on APB
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/100ps
`include "uic_cfg.svh"
module uic_uart_ctrl import uic_pkg::*; #(parameter int DMA_CH = 16) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] src_tick,
  input wire logic debug_mode,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe,
  output logic input_pullup_enable,
  output logic irq,
  output logic [DMA_CH-1:0] dma_req
);
  logic [15:0] clk_q;
  uic_mode_t mode_q;
  logic [11:0] br_q;
  logic module_enable_q;
  logic [2:0] srst_cnt_q;
  logic [7:0] crper_q;
  logic [6:0] inte_q;
  logic [DMA_CH-1:0] tdma_q, rdma_q, dma_q;
  uic_flags_t flags_q;
  logic [31:0] prdata_q, rdata_d;
  logic pready_q, pslverr_q, map_ok, irq_q;
  logic acc, wr_en, rd_en, srst_busy, run, op_tick, sample_tick;
  logic [6:0] w1c;
  logic [7:0] txbuf_q;
  logic txfull_q, tx_wr, tx_load, tx_done, tx_bit_end, tx_stop2_q, tx_par_q, tx_bit;
  uic_line_st_t tx_st_q, rx_st_q;
  logic [3:0] tx_cnt_q, rx_cnt_q, ovs_last, rx_lim;
  logic [2:0] tx_bitn_q, rx_bitn_q, last_bit;
  logic [7:0] tx_sh_q, rx_sh_q, rx_data, car_cnt_q;
  logic rx_s1_q, rx_s2_q, rxd, rx_par_q, rx_bit_end, rx_done, rx_fe, rx_pe;
  logic rx_push, rx_pop, car_q, line_bit, mod_bit;
  logic [1:0] fifo_cnt, nh_err;
  logic [9:0] fifo_head, fifo_next;
  logic serial_out_q, serial_out_oe_q;

  // APB handshake: one wait state, then the access completes
  assign acc = psel & penable & pready_q;
  assign wr_en = acc & pwrite;
  assign rd_en = acc & ~pwrite;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign serial_out_pin = serial_out_q;
  assign serial_out_oe = serial_out_oe_q;
  assign input_pullup_enable = mode_q.input_pullup_enable;
  assign irq = irq_q;
  assign dma_req = dma_q;
  assign srst_busy = srst_cnt_q != 3'h0;
  assign run = module_enable_q & (~debug_mode | clk_q[`UIC_CLK_DEBUG_RUN]);

  // Read mux; reserved bits come back as zero
  always_comb begin
    rdata_d = 32'h0;
    map_ok = 1'b1;
    case (paddr)
      `UIC_OFS_CLK: rdata_d = {16'h0, clk_q};
      `UIC_OFS_MOD: rdata_d = {16'h0, mode_q};
      `UIC_OFS_BR: rdata_d = {20'h0, br_q};
      `UIC_OFS_CTL: rdata_d = {30'h0, srst_busy, module_enable_q};
      `UIC_OFS_TXD: rdata_d = {24'h0, txbuf_q};
      `UIC_OFS_RXD: rdata_d = {24'h0, fifo_head[7:0]};
      `UIC_OFS_INTF: rdata_d = {22'h0, rx_st_q != UIC_IDLE, tx_st_q != UIC_IDLE, 1'b0, flags_q};
      `UIC_OFS_INTE: rdata_d = {25'h0, inte_q};
      `UIC_OFS_TDMA: rdata_d = 32'(tdma_q);
      `UIC_OFS_RDMA: rdata_d = 32'(rdma_q);
      `UIC_OFS_CAWF: rdata_d = {24'h0, crper_q};
      default: map_ok = 1'b0;
    endcase
  end

  // Bus answer, captured in the cycle before pready rises
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
        prdata_q <= pwrite ? 32'h0 : rdata_d;
        pslverr_q <= ~map_ok;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // Configuration registers, reserved bits masked on write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      clk_q <= 16'h0;
      mode_q <= '0;
      br_q <= 12'h0;
      module_enable_q <= 1'b0;
      inte_q <= 7'h0;
      tdma_q <= '0;
      rdma_q <= '0;
      crper_q <= 8'h0;
    end else if (wr_en) begin
      case (paddr)
        `UIC_OFS_CLK: clk_q <= pwdata[15:0] & `UIC_MSK_CLK;
        `UIC_OFS_MOD: mode_q <= uic_mode_t'(pwdata[15:0] & `UIC_MSK_MOD);
        `UIC_OFS_BR: br_q <= pwdata[11:0] & `UIC_MSK_BR;
        `UIC_OFS_CTL: module_enable_q <= pwdata[`UIC_CTL_MODULE_ENABLE];
        `UIC_OFS_INTE: inte_q <= pwdata[6:0];
        `UIC_OFS_TDMA: tdma_q <= pwdata[DMA_CH-1:0];
        `UIC_OFS_RDMA: rdma_q <= pwdata[DMA_CH-1:0];
        `UIC_OFS_CAWF: crper_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Soft reset runs a fixed number of cycles, then clears itself
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      srst_cnt_q <= 3'h0;
    end else if (wr_en && paddr == `UIC_OFS_CTL && pwdata[`UIC_CTL_SOFT_RESET]) begin
      srst_cnt_q <= `UIC_SRST_CYCLES;
    end else if (srst_busy) begin
      srst_cnt_q <= srst_cnt_q - 3'h1;
    end
  end

  uic_clk_gen u_clk (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .src_tick(src_tick),
    .clk_src(clk_q[`UIC_CLK_SRC_LSB +: 2]),
    .clk_div(clk_q[`UIC_CLK_DIV_LSB +: 2]),
    .run(run),
    .reload(br_q[`UIC_BR_RELOAD_LSB +: 8]),
    .op_tick(op_tick),
    .sample_tick(sample_tick)
  );

  // Per-bit sample counts and character framing
  assign ovs_last = mode_q.baud_prescale_select ? `UIC_OVS_FAST : `UIC_OVS_SLOW;
  assign last_bit = mode_q.char_length_select ? 3'h7 : 3'h6;
  assign tx_wr = wr_en && paddr == `UIC_OFS_TXD;
  assign tx_load = sample_tick && tx_st_q == UIC_IDLE && txfull_q && !tx_wr && !srst_busy;
  assign tx_bit_end = sample_tick && tx_cnt_q == ovs_last;
  assign tx_done = tx_bit_end && tx_st_q == UIC_STOP && (!mode_q.stop_length_select || tx_stop2_q);

  // Transmit buffer
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      txbuf_q <= 8'h0;
      txfull_q <= 1'b0;
    end else if (srst_busy) begin
      txfull_q <= 1'b0;
    end else if (tx_wr) begin
      txbuf_q <= pwdata[7:0];
      txfull_q <= 1'b1;
    end else if (tx_load) begin
      txfull_q <= 1'b0;
    end
  end

  // Transmit engine
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tx_st_q <= UIC_IDLE;
      tx_cnt_q <= 4'h0;
      tx_bitn_q <= 3'h0;
      tx_sh_q <= 8'h0;
      tx_par_q <= 1'b0;
      tx_stop2_q <= 1'b0;
    end else if (srst_busy) begin
      tx_st_q <= UIC_IDLE;
      tx_cnt_q <= 4'h0;
    end else if (sample_tick) begin
      tx_cnt_q <= (tx_st_q == UIC_IDLE || tx_bit_end) ? 4'h0 : tx_cnt_q + 4'h1;
      unique case (tx_st_q)
        UIC_IDLE: if (tx_load) begin
          tx_st_q <= UIC_START;
          tx_sh_q <= txbuf_q;
          tx_par_q <= ^{mode_q.char_length_select & txbuf_q[7], txbuf_q[6:0]} ^ mode_q.parity_odd_select;
        end
        UIC_START: if (tx_bit_end) begin
          tx_st_q <= UIC_DATA;
          tx_bitn_q <= 3'h0;
        end
        UIC_DATA: if (tx_bit_end) begin
          tx_sh_q <= {1'b0, tx_sh_q[7:1]};
          tx_bitn_q <= tx_bitn_q + 3'h1;
          if (tx_bitn_q == last_bit) begin
            tx_st_q <= mode_q.parity_enable ? UIC_PAR : UIC_STOP;
            tx_stop2_q <= 1'b0;
          end
        end
        UIC_PAR: if (tx_bit_end) begin
          tx_st_q <= UIC_STOP;
        end
        UIC_STOP: if (tx_bit_end) begin
          tx_stop2_q <= 1'b1;
          if (tx_done) begin
            tx_st_q <= UIC_IDLE;
          end
        end
        default: tx_st_q <= UIC_IDLE;
      endcase
    end
  end

  // Receive line synchroniser and optional inversion
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= serial_in_pin;
      rx_s2_q <= rx_s1_q;
    end
  end
  assign rxd = rx_s2_q ^ mode_q.rx_line_invert;

  // Receive framing and error checks
  assign rx_lim = (rx_st_q != UIC_START) ? ovs_last :
    (mode_q.baud_prescale_select ? `UIC_HALF_FAST : `UIC_HALF_SLOW);
  assign rx_bit_end = sample_tick && rx_st_q != UIC_IDLE && rx_cnt_q == rx_lim;
  assign rx_done = rx_bit_end && rx_st_q == UIC_STOP;
  assign rx_data = mode_q.char_length_select ? rx_sh_q : {1'b0, rx_sh_q[7:1]};
  assign rx_fe = ~rxd;
  assign rx_pe = mode_q.parity_enable & ((^rx_data ^ rx_par_q) != mode_q.parity_odd_select);

  // Receive engine
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx_st_q <= UIC_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bitn_q <= 3'h0;
      rx_sh_q <= 8'h0;
      rx_par_q <= 1'b0;
    end else if (srst_busy) begin
      rx_st_q <= UIC_IDLE;
      rx_cnt_q <= 4'h0;
    end else if (sample_tick) begin
      rx_cnt_q <= (rx_st_q == UIC_IDLE || rx_bit_end) ? 4'h0 : rx_cnt_q + 4'h1;
      unique case (rx_st_q)
        UIC_IDLE: if (!rxd) begin
          rx_st_q <= UIC_START;
        end
        UIC_START: if (rx_bit_end) begin
          rx_st_q <= rxd ? UIC_IDLE : UIC_DATA;
          rx_bitn_q <= 3'h0;
        end
        UIC_DATA: if (rx_bit_end) begin
          rx_sh_q <= {rxd, rx_sh_q[7:1]};
          rx_bitn_q <= rx_bitn_q + 3'h1;
          if (rx_bitn_q == last_bit) begin
            rx_st_q <= mode_q.parity_enable ? UIC_PAR : UIC_STOP;
          end
        end
        UIC_PAR: if (rx_bit_end) begin
          rx_par_q <= rxd;
          rx_st_q <= UIC_STOP;
        end
        UIC_STOP: if (rx_bit_end) begin
          rx_st_q <= UIC_IDLE;
        end
        default: rx_st_q <= UIC_IDLE;
      endcase
    end
  end

  // A full buffer drops the new character
  assign rx_push = rx_done && fifo_cnt != 2'h2 && !srst_busy;
  assign rx_pop = rd_en && paddr == `UIC_OFS_RXD && fifo_cnt != 2'h0;

  uic_rx_fifo #(.W(10)) u_fifo (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(srst_busy),
    .push(rx_push),
    .pop(rx_pop),
    .wdata({rx_fe, rx_pe, rx_data}),
    .count(fifo_cnt),
    .head(fifo_head),
    .next(fifo_next)
  );

  // Error bits of a byte that just became readable
  always_comb begin
    if (rx_push && (fifo_cnt == 2'h0 || (rx_pop && fifo_cnt == 2'h1))) begin
      nh_err = {rx_fe, rx_pe};
    end else if (rx_pop && fifo_cnt == 2'h2) begin
      nh_err = fifo_next[9:8];
    end else begin
      nh_err = 2'h0;
    end
  end
  assign w1c = (wr_en && paddr == `UIC_OFS_INTF) ? pwdata[6:0] : 7'h0;

  // Sticky flags; a set event beats a write-one or read clear in the same cycle, but soft reset beats a set event
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags_q <= uic_flags_t'(`UIC_FLAGS_RST);
    end else if (srst_busy) begin
      flags_q <= uic_flags_t'(`UIC_FLAGS_RST);
    end else begin
      flags_q.tend <= (tx_done & flags_q.tbe) | (flags_q.tend & ~w1c[6]);
      flags_q.fe <= nh_err[1] | (flags_q.fe & ~w1c[5] & ~(rx_pop & fifo_head[9]));
      flags_q.pe <= nh_err[0] | (flags_q.pe & ~w1c[4] & ~(rx_pop & fifo_head[8]));
      flags_q.oe <= (rx_done & fifo_cnt == 2'h2) | (flags_q.oe & ~w1c[3]);
      flags_q.rb2 <= (rx_push & fifo_cnt == 2'h1 & ~rx_pop) | (flags_q.rb2 & ~rx_pop);
      flags_q.rb1 <= (rx_push & fifo_cnt == 2'h0) | (flags_q.rb1 & ~(rx_pop & fifo_cnt == 2'h1 & ~rx_push));
      flags_q.tbe <= tx_load | (flags_q.tbe & ~tx_wr);
    end
  end

  // Interrupt and DMA request outputs
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
      dma_q <= '0;
    end else begin
      irq_q <= |(flags_q & inte_q);
      dma_q <= (flags_q.rb1 ? rdma_q : '0) | (flags_q.tbe ? tdma_q : '0);
    end
  end

  // Carrier waveform from the operating clock
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      car_cnt_q <= 8'h0;
      car_q <= 1'b0;
    end else if (op_tick) begin
      car_cnt_q <= (car_cnt_q == crper_q) ? 8'h00 : car_cnt_q + 8'h01;
      car_q <= car_q ^ (car_cnt_q == crper_q);
    end
  end

  // Output bit with infrared pulse shaping and carrier
  always_comb begin
    unique case (tx_st_q)
      UIC_START: tx_bit = 1'b0;
      UIC_DATA: tx_bit = tx_sh_q[0];
      UIC_PAR: tx_bit = tx_par_q;
      default: tx_bit = 1'b1;
    endcase
    line_bit = tx_bit | (mode_q.infrared_mode_enable & (tx_cnt_q >= `UIC_IR_PULSE));
    mod_bit = (mode_q.carrier_enable && line_bit == mode_q.carrier_phase_select) ? car_q : line_bit;
  end

  // Serial output pin; open drain drives only the low level
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_out_q <= 1'b1;
      serial_out_oe_q <= 1'b1;
    end else begin
      serial_out_q <= mod_bit ^ mode_q.tx_line_invert;
      serial_out_oe_q <= ~mode_q.output_drive_mode | ~(mod_bit ^ mode_q.tx_line_invert);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  // Checks on flag, request, soft reset and gating behaviour
  AST_TBE_CLEAR: assert property (tx_wr && !srst_busy |=> !flags_q.tbe) else $error("tbe not cleared");
  AST_TBE_SET: assert property (tx_load |=> flags_q.tbe ##1 tx_st_q == UIC_START) else $error("tbe load");
  AST_OE_READ: assert property (rx_pop && flags_q.oe && !w1c[3] && !srst_busy |=> flags_q.oe)
    else $error("oe lost on read");
  AST_OVR_DROP: assert property (rx_done && fifo_cnt == 2'h2 && !rx_pop && !srst_busy
    |=> flags_q.oe && fifo_cnt == 2'h2) else $error("overrun mishandled");
  AST_IRQ_GATE: assert property ((flags_q & inte_q) == 7'h0 |=> !irq_q) else $error("irq without enabled flag");
  AST_DMA_GATE: assert property (!flags_q.rb1 && !flags_q.tbe |=> dma_q == '0) else $error("dma without cause");
  AST_SRST_SELF: assert property ($rose(srst_busy) |-> srst_busy [*4] ##1 !srst_busy) else $error("soft reset length");
  AST_SRST_FLAGS: assert property (srst_busy |=> flags_q == uic_flags_t'(`UIC_FLAGS_RST)) else $error("flags not reset");
  AST_TEND_SET: assert property (tx_done && flags_q.tbe && !srst_busy |=> flags_q.tend) else $error("tend not set");
  AST_RB2_SET: assert property (rx_push && fifo_cnt == 2'h1 && !rx_pop |=> flags_q.rb2 && fifo_cnt == 2'h2)
    else $error("rb2 not set");
  AST_GATE_OFF: assert property (!run && !srst_busy |=> $stable(tx_st_q) && $stable(rx_st_q)) else $error("ran while gated");
endmodule

// *** uic_remote.sv ***
// Remote serial device model driving and watching the serial line
`timescale 1ns/100ps
module uic_remote #(parameter int BIT = 8) (
  input wire logic clk_sys,
  input wire logic line_from_dut,
  output logic line_to_dut
);
  // Line idles high between frames
  initial line_to_dut = 1'b1;
  // Send start, eight data bits LSB first, then a stop bit of the given level
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      line_to_dut <= f[i];
      repeat (BIT - 1) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    line_to_dut <= 1'b1;
    repeat (BIT * 2) @(posedge clk_sys);
  endtask
  // Receive one frame, sampling each data bit near its middle
  task automatic recv(output logic [7:0] d);
    @(negedge line_from_dut);
    repeat (BIT + BIT / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      d[i] = line_from_dut;
      repeat (BIT) @(posedge clk_sys);
    end
  endtask
endmodule

// *** uic_uart_ctrl_bench.sv ***
// Self-checking bench for the serial port control block
`timescale 1ns/100ps
module uic_uart_ctrl_bench;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, last_err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] src_tick = 4'hf;
  logic debug_mode = 1'b0;
  logic serial_in_pin, serial_out_pin, serial_out_oe, input_pullup_enable, irq;
  logic [15:0] dma_req;
  logic [7:0] b;
  logic [7:0] regs [4] = '{8'h00, 8'h04, 8'h08, 8'h28};
  logic [31:0] msks [4] = '{32'h133, 32'h1f6f, 32'hfff, 32'hff};
  int errors = 0, comparisons = 0;
  uic_uart_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_tick(src_tick), .debug_mode(debug_mode), .serial_in_pin(serial_in_pin),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .input_pullup_enable(input_pullup_enable), .irq(irq), .dma_req(dma_req));
  uic_remote u_rem (.clk_sys(clk_sys), .line_from_dut(serial_out_pin), .line_to_dut(serial_in_pin));
  // Clock of 20 ns period
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(n, r, exp);
  endtask
  task automatic results();
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    results();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    rdc("ctl", 8'h0c, 32'h0);
    rdc("intf", 8'h18, 32'h1);
    rdc("inte", 8'h1c, 32'h0);
    chk("oe", {31'h0, serial_out_oe}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(regs[i], (i == 1) ? 32'hffffffef : 32'hffffffff);
      rdc("cfg", regs[i], msks[i]);
      if (i == 1) chk("pullup", {31'h0, input_pullup_enable}, 32'h1);
      wr(regs[i], 32'h0);
    end
    rdc("unmapped", 8'h2c, 32'h0);
    chk("slverr", {31'h0, last_err}, 32'h1);
    wr(8'h04, 32'h0408);
    wr(8'h08, 32'h0001);
    wr(8'h0c, 32'h3);
    repeat (8) @(posedge clk_sys);
    wr(8'h1c, 32'h40);
    fork
      wr(8'h10, 32'h5a);
      u_rem.recv(b);
    join
    chk("txbyte", {24'h0, b}, 32'h5a);
    repeat (24) @(posedge clk_sys);
    rdc("intf", 8'h18, 32'h41);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(8'h18, 32'h40);
    repeat (2) @(posedge clk_sys);
    chk("irq", {31'h0, irq}, 32'h0);
    rdc("intf", 8'h18, 32'h1);
    wr(8'h1c, 32'h0);
    wr(8'h20, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk("dma", {16'h0, dma_req}, 32'h1);
    wr(8'h20, 32'h0);
    wr(8'h24, 32'h4);
    u_rem.send(8'h33, 1'b1);
    rdc("intf", 8'h18, 32'h3);
    chk("dma", {16'h0, dma_req}, 32'h4);
    u_rem.send(8'h44, 1'b1);
    rdc("intf", 8'h18, 32'h7);
    u_rem.send(8'h55, 1'b1);
    rdc("intf", 8'h18, 32'hf);
    rdc("rxd", 8'h14, 32'h33);
    rdc("intf", 8'h18, 32'hb);
    rdc("rxd", 8'h14, 32'h44);
    rdc("intf", 8'h18, 32'h9);
    chk("dma", {16'h0, dma_req}, 32'h0);
    wr(8'h18, 32'h8);
    rdc("intf", 8'h18, 32'h1);
    wr(8'h24, 32'h0);
    u_rem.send(8'h66, 1'b0);
    rdc("intf", 8'h18, 32'h23);
    rdc("rxd", 8'h14, 32'h66);
    rdc("intf", 8'h18, 32'h1);
    u_rem.send(8'h77, 1'b1);
    wr(8'h0c, 32'h3);
    rdc("ctl busy", 8'h0c, 32'h3);
    repeat (8) @(posedge clk_sys);
    rdc("ctl", 8'h0c, 32'h1);
    rdc("intf", 8'h18, 32'h1);
    results();
  end
endmodule
